// >>> core/ttc_enable_mem.sv
// one trace enable bit per program address, two registered read ports
`timescale 1ns/1ps
`include "ttc_regs.svh"
module ttc_enable_mem (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  ttc_mem_if.mem mem
);
  ttc_pkg::ttc_mem_s q;
  ttc_pkg::ttc_mem_s d;

  // write port plus registered reads, reads see the old contents
  always_comb begin
    d = q;
    if (mem.we) begin
      d.bits[mem.host_addr] = mem.wdata;
    end
    d.host_bit = q.bits[mem.host_addr];
    d.look_bit = q.bits[mem.look_addr];
  end

  // contents survive reset, only the read registers clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q.bits <= d.bits;
      q.host_bit <= 1'b0;
      q.look_bit <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign mem.host_bit = q.host_bit;
  assign mem.look_bit = q.look_bit;
endmodule

// >>> core/ttc_mem_if.sv
// link between the trigger logic and the enable bit memory
`timescale 1ns/1ps
interface ttc_mem_if;
  logic we;
  logic [14:0] host_addr;
  logic wdata;
  logic host_bit;
  logic [14:0] look_addr;
  logic look_bit;
  modport mem (input we, input host_addr, input wdata, input look_addr, output host_bit, output look_bit);
  modport user (output we, output host_addr, output wdata, output look_addr, input host_bit, input look_bit);
endinterface

// >>> core/ttc_pkg.sv
// types shared by the trace trigger block
`include "ttc_regs.svh"
package ttc_pkg;

  typedef enum logic [2:0] {
    TTC_FREE, TTC_ENBIT, TTC_OFF, TTC_WINDOW, TTC_AFTER, TTC_BEFORE
  } ttc_mode_e;

  typedef enum logic [1:0] {TTC_ST_ADDR, TTC_ST_RANGE, TTC_ST_RUN} ttc_start_e;
  typedef enum logic [1:0] {TTC_SP_ADDR, TTC_SP_RANGE, TTC_SP_NONE} ttc_stop_e;
  typedef enum logic [1:0] {TTC_OPM_SMALL, TTC_OPM_MID, TTC_OPM_EXP} ttc_opmode_e;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] start_kind;
    logic [1:0] stop_kind;
    logic src_ram;
    logic brk_match;
    logic [1:0] opmode;
    logic [14:0] start_lo;
    logic [14:0] start_hi;
    logic [14:0] stop_lo;
    logic [14:0] stop_hi;
    logic [7:0] mval;
    logic [7:0] mmask;
    logic [11:0] ram_addr;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic pair_xy;
    logic [14:0] en_addr;
    logic [7:0] probe_m;
    logic [7:0] probe_s;
    logic run;
    logic s1_valid;
    logic s1_brk;
    logic [14:0] s1_addr;
    logic [23:0] s1_entry;
    logic active;
    logic armed;
    logic matched;
    logic [15:0] ptr;
    logic wr;
    logic [14:0] loc;
    logic [23:0] data;
    logic [31:0] rdata;
  } ttc_state_s;

  typedef struct packed {
    logic [`TTC_EN_DEPTH-1:0] bits;
    logic host_bit;
    logic look_bit;
  } ttc_mem_s;

endpackage

// >>> core/ttc_regs.svh
// register offsets, field positions, reset values and limits of the trace trigger block
`ifndef TTC_REGS_SVH
`define TTC_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TTC_OFF_CTRL 8'h00
`define TTC_OFF_START 8'h04
`define TTC_OFF_STOP 8'h08
`define TTC_OFF_MATCH 8'h0c
`define TTC_OFF_OBJ 8'h10
`define TTC_OFF_ENADDR 8'h14
`define TTC_OFF_ENDATA 8'h18
`define TTC_OFF_STATUS 8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TTC_CTRL_MODE 2:0
`define TTC_CTRL_START 4:3
`define TTC_CTRL_STOP 6:5
`define TTC_CTRL_SRC 7
`define TTC_CTRL_BRK 8
`define TTC_CTRL_OPM 10:9
`define TTC_RANGE_LO 14:0
`define TTC_RANGE_HI 30:16
`define TTC_MATCH_VAL 7:0
`define TTC_MATCH_MASK 15:8
`define TTC_MATCH_RAM 27:16
`define TTC_OBJ_SEL_A 2:0
`define TTC_OBJ_SEL_B 6:4
`define TTC_OBJ_PAIR 8
`define TTC_EN_ADDR 14:0
`define TTC_EN_BIT 0
`define TTC_NIB_MASK 8'h0f

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define TTC_CTRL_RST 32'h0000_0040
`define TTC_OBJ_RST 32'h0000_0010
`define TTC_PTR_ZERO 16'h0000
`define TTC_PTR_INC 16'h0001
`define TTC_LIM_SMALL 15'h07df
`define TTC_LIM_MID 15'h0fdf
`define TTC_LIM_EXP 15'h7fff
`define TTC_EN_DEPTH 32768

`endif

// >>> core/ttc_top.sv
// trace trigger and trace enable logic of the emulator
//
// Overview of operation
// - free-running mode records every executed instruction during a run
// - enable-bit mode records only instructions whose enable bit is set
// - disabled mode records nothing
// - window starts at the start address, or at the beginning of a run
// - range start begins recording when an address falls inside the inclusive range
// - window stops when the stop address executes
// - range stop ends recording when an address lies inside the range
// - the instruction at the stop address is not recorded
// - with no stop, record to the end of the run, break instructions included
// - after-match mode starts recording at the first masked data match
// - before-match mode stops recording at the first masked data match
// - match source is eight probe pins or one ram nibble
// - mask bits at zero drop that bit from the comparison
// - reset leaves the trigger in free-running mode
// - data-match trigger with data-match break falls back to free-running
// - one enable bit per program address, limit set by operating mode
// - enable bit is checked per executed instruction, record when one
// - only the bit at an instruction's first byte qualifies recording
// - changing traced objects clears the trace pointer
// - an entry holds two selected ports, a, b and one register pair
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ttc_regs.svh"
module ttc_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic run_i,
  input wire logic exec_valid_i,
  input wire logic [14:0] exec_addr_i,
  input wire logic exec_brk_i,
  input wire logic [19:0] port_data_i,
  input wire logic [7:0] reg_ab_i,
  input wire logic [7:0] reg_hl_i,
  input wire logic [7:0] reg_xy_i,
  input wire logic [7:0] probe_pins_i,
  input wire logic ram_wr_i,
  input wire logic [11:0] ram_addr_i,
  input wire logic [3:0] ram_data_i,
  output logic trace_wr_o,
  output logic [15:0] trace_ptr_o,
  output logic [14:0] trace_loc_o,
  output logic [23:0] trace_data_o
);
  ttc_pkg::ttc_state_s q;
  ttc_pkg::ttc_state_s d;
  ttc_mem_if mif ();

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // enable bits exist only up to the limit of the operating mode
  function automatic logic in_range(input logic [14:0] a, input logic [1:0] opm);
    logic ok;
    ok = 1'b0;
    unique case (ttc_pkg::ttc_opmode_e'(opm))
      ttc_pkg::TTC_OPM_SMALL: ok = (a <= `TTC_LIM_SMALL);
      ttc_pkg::TTC_OPM_MID: ok = (a <= `TTC_LIM_MID);
      ttc_pkg::TTC_OPM_EXP: ok = (a <= `TTC_LIM_EXP);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // pick one of the five traced nibbles, unknown selects give zero
  function automatic logic [3:0] pick_port(input logic [19:0] p, input logic [2:0] sel);
    logic [3:0] n;
    n = 4'h0;
    if (sel <= 3'h4) begin
      n = p[sel*4 +: 4];
    end
    return n;
  endfunction

  // address compare against a single address or an inclusive range
  function automatic logic hit(input logic [14:0] a, input logic [14:0] lo, input logic [14:0] hi,
                               input logic is_range);
    logic h;
    h = is_range ? ((a >= lo) && (a <= hi)) : (a == lo);
    return h;
  endfunction

  // ----------------------------------------------------------------
  // enable bit memory
  // ----------------------------------------------------------------
  ttc_enable_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .mem(mif.mem)
  );

  // host port writes bits, lookup follows the executed first-byte address
  assign mif.host_addr = q.en_addr;
  assign mif.wdata = wdata_i[`TTC_EN_BIT];
  assign mif.we = we_i && (addr_i == `TTC_OFF_ENDATA) && in_range(q.en_addr, q.opmode);
  assign mif.look_addr = exec_addr_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic probe_eq;
  logic ram_eq;
  logic match_now;
  logic start_hit;
  logic stop_hit;
  logic rec;
  logic run_rise;
  logic [3:0] nib_mask;
  logic [7:0] pair;

  // masked data compare on probe pins or the watched ram nibble
  always_comb begin
    nib_mask = q.mmask[3:0] & 4'(`TTC_NIB_MASK);
    probe_eq = ((q.probe_s & q.mmask) == (q.mval & q.mmask));
    ram_eq = ram_wr_i && (ram_addr_i == q.ram_addr) && ((ram_data_i & nib_mask) == (q.mval[3:0] & nib_mask));
    match_now = q.src_ram ? ram_eq : probe_eq;
  end

  // window start and stop detection for the instruction in stage one
  always_comb begin
    start_hit = 1'b0;
    stop_hit = 1'b0;
    if (ttc_pkg::ttc_start_e'(q.start_kind) != ttc_pkg::TTC_ST_RUN) begin
      start_hit = hit(q.s1_addr, q.start_lo, q.start_hi,
                      ttc_pkg::ttc_start_e'(q.start_kind) == ttc_pkg::TTC_ST_RANGE);
    end
    if (ttc_pkg::ttc_stop_e'(q.stop_kind) != ttc_pkg::TTC_SP_NONE) begin
      stop_hit = hit(q.s1_addr, q.stop_lo, q.stop_hi,
                     ttc_pkg::ttc_stop_e'(q.stop_kind) == ttc_pkg::TTC_SP_RANGE);
    end
  end

  // main update: bus, stage one capture, trigger decision, pointer
  always_comb begin
    d = q;
    rec = 1'b0;
    run_rise = run_i && !q.run;
    pair = q.pair_xy ? reg_xy_i : reg_hl_i;
    d.wr = 1'b0;
    d.rdata = 32'h0000_0000;
    d.run = run_i;
    // probe pins come from outside, two flops before use
    d.probe_m = probe_pins_i;
    d.probe_s = q.probe_m;

    // stage one holds the instruction while its enable bit is read
    d.s1_valid = exec_valid_i && run_i;
    d.s1_addr = exec_addr_i;
    d.s1_brk = exec_brk_i;
    d.s1_entry = {pick_port(port_data_i, q.sel_a), pick_port(port_data_i, q.sel_b), reg_ab_i, pair};

    // a new run restarts the window and the match flags
    if (run_rise) begin
      d.active = (ttc_pkg::ttc_start_e'(q.start_kind) == ttc_pkg::TTC_ST_RUN);
      d.armed = 1'b0;
      d.matched = 1'b0;
    end

    // recording decision per trigger mode, taken even if run drops after the last instruction
    if (q.s1_valid) begin
      unique case (ttc_pkg::ttc_mode_e'(q.mode))
        ttc_pkg::TTC_FREE: begin
          rec = 1'b1;
        end
        ttc_pkg::TTC_ENBIT: begin
          rec = mif.look_bit && in_range(q.s1_addr, q.opmode);
        end
        ttc_pkg::TTC_OFF: begin
          rec = 1'b0;
        end
        ttc_pkg::TTC_WINDOW: begin
          rec = (q.active || start_hit) && !stop_hit;
          if ((ttc_pkg::ttc_stop_e'(q.stop_kind) != ttc_pkg::TTC_SP_NONE) && q.s1_brk) begin
            rec = 1'b0;
          end
          if (stop_hit) begin
            d.active = 1'b0;
          end else if (start_hit) begin
            d.active = 1'b1;
          end
        end
        ttc_pkg::TTC_AFTER: begin
          rec = q.armed || match_now;
          d.armed = q.armed || match_now;
        end
        ttc_pkg::TTC_BEFORE: begin
          rec = !(q.matched || match_now);
          d.matched = q.matched || match_now;
        end
        default: begin
          rec = 1'b1;
        end
      endcase
    end

    // one slot per recorded instruction
    if (rec) begin
      d.wr = 1'b1;
      d.ptr = q.ptr + `TTC_PTR_INC;
      d.loc = q.s1_addr;
      d.data = q.s1_entry;
    end

    // data-match trigger cannot share the match logic with a match break
    if (q.brk_match && ((ttc_pkg::ttc_mode_e'(q.mode) == ttc_pkg::TTC_AFTER) ||
                        (ttc_pkg::ttc_mode_e'(q.mode) == ttc_pkg::TTC_BEFORE))) begin
      d.mode = 3'(ttc_pkg::TTC_FREE);
    end

    // register writes, a fresh trigger write wins over the fallback
    if (we_i) begin
      unique case (addr_i)
        `TTC_OFF_CTRL: begin
          d.mode = wdata_i[`TTC_CTRL_MODE];
          d.start_kind = wdata_i[`TTC_CTRL_START];
          d.stop_kind = wdata_i[`TTC_CTRL_STOP];
          d.src_ram = wdata_i[`TTC_CTRL_SRC];
          d.brk_match = wdata_i[`TTC_CTRL_BRK];
          d.opmode = wdata_i[`TTC_CTRL_OPM];
          d.armed = 1'b0;
          d.matched = 1'b0;
        end
        `TTC_OFF_START: begin
          d.start_lo = wdata_i[`TTC_RANGE_LO];
          d.start_hi = wdata_i[`TTC_RANGE_HI];
        end
        `TTC_OFF_STOP: begin
          d.stop_lo = wdata_i[`TTC_RANGE_LO];
          d.stop_hi = wdata_i[`TTC_RANGE_HI];
        end
        `TTC_OFF_MATCH: begin
          d.mval = wdata_i[`TTC_MATCH_VAL];
          d.mmask = wdata_i[`TTC_MATCH_MASK];
          d.ram_addr = wdata_i[`TTC_MATCH_RAM];
        end
        `TTC_OFF_OBJ: begin
          d.sel_a = wdata_i[`TTC_OBJ_SEL_A];
          d.sel_b = wdata_i[`TTC_OBJ_SEL_B];
          d.pair_xy = wdata_i[`TTC_OBJ_PAIR];
          d.ptr = `TTC_PTR_ZERO;
        end
        `TTC_OFF_ENADDR: begin
          d.en_addr = wdata_i[`TTC_EN_ADDR];
        end
        default: begin
        end
      endcase
    end

    // register reads, data stand in the next cycle only
    if (re_i) begin
      unique case (addr_i)
        `TTC_OFF_CTRL: begin
          d.rdata[`TTC_CTRL_MODE] = q.mode;
          d.rdata[`TTC_CTRL_START] = q.start_kind;
          d.rdata[`TTC_CTRL_STOP] = q.stop_kind;
          d.rdata[`TTC_CTRL_SRC] = q.src_ram;
          d.rdata[`TTC_CTRL_BRK] = q.brk_match;
          d.rdata[`TTC_CTRL_OPM] = q.opmode;
        end
        `TTC_OFF_START: begin
          d.rdata[`TTC_RANGE_LO] = q.start_lo;
          d.rdata[`TTC_RANGE_HI] = q.start_hi;
        end
        `TTC_OFF_STOP: begin
          d.rdata[`TTC_RANGE_LO] = q.stop_lo;
          d.rdata[`TTC_RANGE_HI] = q.stop_hi;
        end
        `TTC_OFF_MATCH: begin
          d.rdata[`TTC_MATCH_VAL] = q.mval;
          d.rdata[`TTC_MATCH_MASK] = q.mmask;
          d.rdata[`TTC_MATCH_RAM] = q.ram_addr;
        end
        `TTC_OFF_OBJ: begin
          d.rdata[`TTC_OBJ_SEL_A] = q.sel_a;
          d.rdata[`TTC_OBJ_SEL_B] = q.sel_b;
          d.rdata[`TTC_OBJ_PAIR] = q.pair_xy;
        end
        `TTC_OFF_ENADDR: begin
          d.rdata[`TTC_EN_ADDR] = q.en_addr;
        end
        `TTC_OFF_ENDATA: begin
          d.rdata[`TTC_EN_BIT] = mif.host_bit && in_range(q.en_addr, q.opmode);
        end
        `TTC_OFF_STATUS: begin
          d.rdata = {13'h0000, q.matched, q.armed, q.active, q.ptr};
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // reset leaves free-running trace and default objects
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mode <= 3'(`TTC_CTRL_RST);
      q.stop_kind <= 2'(`TTC_CTRL_RST >> 5);
      q.sel_b <= 3'(`TTC_OBJ_RST >> 4);
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign rdata_o = q.rdata;
  assign trace_wr_o = q.wr;
  assign trace_ptr_o = q.ptr;
  assign trace_loc_o = q.loc;
  assign trace_data_o = q.data;
endmodule

// >>> dv/ttc_core_model.sv
// behavioural model of the emulated core issuing executed instructions
`timescale 1ns/1ps
module ttc_core_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [14:0] first_i,
  input wire logic [7:0] count_i,
  input wire logic [1:0] stride_i,
  input wire logic [1:0] gap_i,
  output logic done_o,
  output logic run_o,
  output logic exec_valid_o,
  output logic [14:0] exec_addr_o,
  output logic exec_brk_o,
  output logic [19:0] port_data_o,
  output logic [7:0] reg_ab_o,
  output logic [7:0] reg_hl_o,
  output logic [7:0] reg_xy_o,
  output logic [7:0] probe_pins_o,
  output logic ram_wr_o,
  output logic [11:0] ram_addr_o,
  output logic [3:0] ram_data_o
);
  int idx;
  int wait_c;
  logic busy;
  logic [31:0] rnd;

  // quiet outputs before the first edge
  initial begin
    busy = 1'b0;
    {done_o, run_o, exec_valid_o, exec_brk_o, ram_wr_o} = 5'h00;
    {exec_addr_o, port_data_o, ram_data_o} = 39'h0;
    {reg_ab_o, reg_hl_o, reg_xy_o, probe_pins_o} = 32'h0;
    ram_addr_o = 12'h0a5;
  end

  // one instruction per slot, gap_i idle cycles between slots
  always @(posedge ref_clk_i) begin
    exec_valid_o <= 1'b0;
    ram_wr_o <= 1'b0;
    done_o <= 1'b0;
    if (exec_valid_o) begin
      probe_pins_o <= idx[7:0];
      ram_wr_o <= 1'b1;
      ram_data_o <= probe_pins_o[3:0];
    end
    if (rst_i) begin
      busy = 1'b0;
      run_o <= 1'b0;
    end else if (go_i) begin
      busy = 1'b1;
      idx = 0;
      wait_c = gap_i + 1;
      run_o <= 1'b1;
      probe_pins_o <= 8'h00;
    end else if (busy) begin
      if (wait_c != 0) begin
        wait_c--;
      end else if (idx == count_i) begin
        busy = 1'b0;
        run_o <= 1'b0;
        done_o <= 1'b1;
      end else begin
        rnd = $urandom;
        exec_valid_o <= 1'b1;
        exec_addr_o <= first_i + 15'(idx * stride_i);
        exec_brk_o <= idx == 15;
        port_data_o <= rnd[19:0];
        reg_ab_o <= rnd[27:20];
        reg_hl_o <= rnd[31:24];
        reg_xy_o <= rnd[15:8];
        idx++;
        wait_c = gap_i;
      end
    end
  end
endmodule

// >>> dv/ttc_top_properties.sv
// concurrent checks on the trace trigger block ports
`timescale 1ns/1ps
module ttc_top_properties (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [31:0] rdata_o,
  input wire logic run_i,
  input wire logic exec_valid_i,
  input wire logic [14:0] exec_addr_i,
  input wire logic [19:0] port_data_i,
  input wire logic [7:0] reg_ab_i,
  input wire logic [7:0] reg_hl_i,
  input wire logic trace_wr_o,
  input wire logic [15:0] trace_ptr_o,
  input wire logic [14:0] trace_loc_o,
  input wire logic [23:0] trace_data_o
);
  logic free_q;
  logic off_q;
  logic dflt_q;
  logic [1:0] obj_gap_q;
  wire took = exec_valid_i && run_i;
  wire [23:0] dflt_entry = {port_data_i[3:0], port_data_i[7:4], reg_ab_i, reg_hl_i};

  // ----------------------------------------------------------------
  // shadow of the written mode and of the last object change
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      free_q <= 1'b1;
      off_q <= 1'b0;
      dflt_q <= 1'b1;
      obj_gap_q <= 2'h3;
    end else begin
      if (we_i && addr_i == 8'h00) begin
        free_q <= wdata_i[2:0] == 3'h0 || wdata_i[2:0] > 3'h5;
        off_q <= wdata_i[2:0] == 3'h2;
      end
      if (we_i && addr_i == 8'h10) begin
        dflt_q <= 1'b0;
        obj_gap_q <= 2'h0;
      end else if (obj_gap_q != 2'h3) begin
        obj_gap_q <= obj_gap_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence taken_s;
    took;
  endsequence
  sequence free_taken_s;
    taken_s ##0 free_q ##1 free_q ##1 free_q;
  endsequence

  rd_slot_zero_a: assert property (!$past(re_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  rd_unmapped_a: assert property (re_i && addr_i > 8'h1c |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  entry_cause_a: assert property (trace_wr_o |-> $past(took, 2))
    else $error("entry without executed instruction");
  entry_loc_a: assert property (trace_wr_o |-> trace_loc_o == $past(exec_addr_i, 2))
    else $error("entry address wrong");
  free_all_a: assert property (free_taken_s |-> trace_wr_o)
    else $error("free mode dropped an instruction");
  off_none_a: assert property (off_q && $past(off_q) && $past(off_q, 2) |-> !trace_wr_o)
    else $error("entry while tracing is off");
  ptr_step_a: assert property (trace_wr_o && obj_gap_q == 2'h3 |-> trace_ptr_o == $past(trace_ptr_o) + 16'h1)
    else $error("pointer did not step by one");
  ptr_hold_a: assert property (!trace_wr_o && obj_gap_q == 2'h3 |-> $stable(trace_ptr_o))
    else $error("pointer moved without entry");
  ptr_clear_a: assert property (we_i && addr_i == 8'h10 |-> ##[1:2] trace_ptr_o == 16'h0)
    else $error("object change kept pointer");
  entry_data_a: assert property (trace_wr_o && dflt_q |-> trace_data_o == $past(dflt_entry, 2))
    else $error("entry data wrong");
endmodule

bind ttc_top ttc_top_properties chk_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .run_i,
  .exec_valid_i, .exec_addr_i, .port_data_i, .reg_ab_i, .reg_hl_i, .trace_wr_o, .trace_ptr_o, .trace_loc_o,
  .trace_data_o);

// >>> dv/ttc_top_test.sv
// self-checking bench for the trace trigger block
`timescale 1ns/1ps
module ttc_top_test;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic go = 1'b0;
  logic [14:0] first = 15'h0;
  logic [7:0] cnt = 8'h00;
  logic [1:0] stride = 2'h1;
  logic [1:0] gap = 2'h0;
  logic [31:0] rdata_o;
  logic run_i, exec_valid_i, exec_brk_i, ram_wr_i, trace_wr_o, done;
  logic [14:0] exec_addr_i, trace_loc_o, first_loc, last_loc;
  logic [19:0] port_data_i;
  logic [7:0] reg_ab_i, reg_hl_i, reg_xy_i, probe_pins_i;
  logic [11:0] ram_addr_i;
  logic [3:0] ram_data_i;
  logic [15:0] trace_ptr_o;
  logic [23:0] trace_data_o;
  int err_total = 0;
  int tests_run = 0;
  int nrec = 0;

  ttc_top dut_u (.ref_clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .run_i, .exec_valid_i,
    .exec_addr_i, .exec_brk_i, .port_data_i, .reg_ab_i, .reg_hl_i, .reg_xy_i, .probe_pins_i, .ram_wr_i,
    .ram_addr_i, .ram_data_i, .trace_wr_o, .trace_ptr_o, .trace_loc_o, .trace_data_o);
  ttc_core_model core_u (.ref_clk_i, .rst_i, .go_i(go), .first_i(first), .count_i(cnt), .stride_i(stride),
    .gap_i(gap), .done_o(done), .run_o(run_i), .exec_valid_o(exec_valid_i), .exec_addr_o(exec_addr_i),
    .exec_brk_o(exec_brk_i), .port_data_o(port_data_i), .reg_ab_o(reg_ab_i), .reg_hl_o(reg_hl_i),
    .reg_xy_o(reg_xy_i), .probe_pins_o(probe_pins_i), .ram_wr_o(ram_wr_i), .ram_addr_o(ram_addr_i),
    .ram_data_o(ram_data_i));

  // ----------------------------------------------------------------
  // clock, entry monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (trace_wr_o === 1'b1) begin
      if (nrec == 0) first_loc = trace_loc_o;
      last_loc = trace_loc_o;
      nrec++;
    end
  end
  initial begin
    #(30000 * 100);
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic int even_ones(input logic [15:0] b);
    int c = 0;
    for (int i = 0; i < 16; i += 2) c += b[i];
    return c;
  endfunction
  function automatic int first_hit(input logic [7:0] v, input logic [7:0] mk);
    for (int i = 0; i < 256; i++) if (((i[7:0] ^ v) & mk) == 8'h00) return i;
    return 256;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expect_run(input int n, input logic [14:0] f, input logic [14:0] l);
    check(nrec, n);
    if (n > 0) begin
      check({17'h0, first_loc}, {17'h0, f});
      check({17'h0, last_loc}, {17'h0, l});
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic prog(input logic [14:0] f, input logic [7:0] n, input logic [1:0] s, input logic [1:0] g);
    @(posedge ref_clk_i);
    first <= f;
    cnt <= n;
    stride <= s;
    gap <= g;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    nrec = 0;
    for (int i = 0; i < 2000 && done !== 1'b1; i++) @(posedge ref_clk_i);
    if (done !== 1'b1) err_total++; // run never finished
    repeat (4) @(posedge ref_clk_i);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [15:0] bits;
    int m;
    void'($urandom(32'hde59));
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(8'h00, d); check(d, 32'h0000_0040);
    rd(8'h10, d); check(d, 32'h0000_0010);
    rd(8'h24, d); check(d, 32'h0);
    // free run of random length, back to back
    m = 4 + $urandom_range(11);
    prog(15'h0100, m[7:0], 2'h1, 2'h0);
    expect_run(m, 15'h0100, 15'h0100 + 15'(m - 1));
    rd(8'h1c, d); check(d & 32'hffff, m);
    wr(8'h00, 32'h2);
    prog(15'h0100, 8'h06, 2'h1, 2'h1);
    expect_run(0, 15'h0, 15'h0);
    wr(8'h10, 32'h0000_0132);
    rd(8'h10, d); check(d, 32'h0000_0132);
    rd(8'h1c, d); check(d & 32'hffff, 0);
    // enable bits on two-byte instructions, odd bytes ignored
    wr(8'h00, 32'h1);
    bits = 16'($urandom) | 16'h4001;
    for (int k = 0; k < 16; k++) begin
      wr(8'h14, 32'h100 + k);
      wr(8'h18, {31'h0, bits[k]});
    end
    prog(15'h0100, 8'h08, 2'h2, 2'h0);
    expect_run(even_ones(bits), 15'h0100, 15'h010e);
    wr(8'h14, 32'h7e0);
    wr(8'h18, 32'h1);
    rd(8'h18, d); check(d & 32'h1, 0);
    wr(8'h14, 32'h7df);
    wr(8'h18, 32'h1);
    rd(8'h18, d); check(d & 32'h1, 1);
    // window by address, by range, and whole run
    wr(8'h04, 32'h0205_0205);
    wr(8'h08, 32'h020a_020a);
    wr(8'h00, 32'h03);
    prog(15'h0200, 8'h10, 2'h1, 2'h0);
    expect_run(5, 15'h0205, 15'h0209);
    wr(8'h04, 32'h0204_0203);
    wr(8'h08, 32'h020e_020c);
    wr(8'h00, 32'h2b);
    prog(15'h0200, 8'h10, 2'h1, 2'h0);
    expect_run(9, 15'h0203, 15'h020b);
    wr(8'h00, 32'h53);
    prog(15'h0200, 8'h10, 2'h1, 2'h0);
    expect_run(16, 15'h0200, 15'h020f);
    // masked probe match, after and before, then ram nibble
    wr(8'h0c, 32'h0000_0cf6);
    m = first_hit(8'hf6, 8'h0c);
    wr(8'h00, 32'h4);
    prog(15'h0300, 8'h0c, 2'h1, 2'h3);
    expect_run(12 - m, 15'h0300 + 15'(m), 15'h030b);
    wr(8'h00, 32'h5);
    prog(15'h0300, 8'h0c, 2'h1, 2'h3);
    expect_run(m, 15'h0300, 15'h0300 + 15'(m - 1));
    wr(8'h0c, 32'h00a5_0302);
    m = first_hit(8'h02, 8'h03);
    wr(8'h00, 32'h84);
    prog(15'h0300, 8'h0c, 2'h1, 2'h3);
    expect_run(12 - m, 15'h0300 + 15'(m), 15'h030b);
    // data match trigger with data match break falls back to free
    wr(8'h0c, 32'h0000_ff05);
    wr(8'h00, 32'h104);
    repeat (2) @(posedge ref_clk_i);
    rd(8'h00, d); check(d & 32'h7, 0);
    prog(15'h0300, 8'h0c, 2'h1, 2'h3);
    expect_run(12, 15'h0300, 15'h030b);
    wrap_up();
  end
endmodule
